/* verilog/sequencer_map.vh */
// constants for the program sequencer and return stack
`ifndef SEQUENCER_MAP_VH
`define SEQUENCER_MAP_VH
`define STACK_INDEX_ADDR   4'h1
`define STACK_INDEX_RESET  4'hC
`define STACK_SLOTS        13
`define SLOT_WIDTH         14
`define SLOT_SEG_BIT       13
`define PC_WIDTH           13
`define PAGE_HI            12
`define PAGE_LO            11
`define TABLE_PTR_WIDTH    14
`define WORD_WIDTH         16
// operation codes from the instruction decoder
`define OP_NONE            4'h0
`define OP_BR_DIRECT       4'h1
`define OP_BR_INDIRECT     4'h2
`define OP_CALL_DIRECT     4'h3
`define OP_CALL_INDIRECT   4'h4
`define OP_SERVICE_CALL    4'h5
`define OP_RETURN          4'h6
`define OP_RETURN_SKIP     4'h7
`define OP_INT_RETURN      4'h8
`define OP_TABLE_FETCH     4'h9
`define OP_PUSH_POINTER    4'hA
`define OP_POP_POINTER     4'hB
`define OP_SKIP            4'hC
// interrupt vectors, highest priority first
`define VEC_FILTERED_PIN   13'h000A
`define VEC_PLAIN_PIN      13'h0009
`define VEC_TIMER0         13'h0008
`define VEC_TIMER1         13'h0007
`define VEC_BASIC_TIMER2   13'h0006
`define VEC_VRAM_POINTER   13'h0005
`define VEC_GROUP1         13'h0004
`define VEC_SERIAL0        13'h0003
`define VEC_SERIAL1        13'h0002
`define VEC_GROUP0         13'h0001
`define SERVICE_SEGMENT    1'b1
`endif

/* verilog/irq_vector_select.v */
// fixed-priority selection of one interrupt vector
`timescale 1ns/1ns
`include "sequencer_map.vh"
module irq_vector_select (
    input  wire [9:0]  pending_in,
    output reg         any_out,
    output reg  [12:0] vector_out
);
    // bit 9 highest (filtered pin) down to bit 0 (group 0)
    always @* begin
        any_out    = 1'b1;
        vector_out = 13'h0000;
        if (pending_in[9])
            vector_out = `VEC_FILTERED_PIN;
        else if (pending_in[8])
            vector_out = `VEC_PLAIN_PIN;
        else if (pending_in[7])
            vector_out = `VEC_TIMER0;
        else if (pending_in[6])
            vector_out = `VEC_TIMER1;
        else if (pending_in[5])
            vector_out = `VEC_BASIC_TIMER2;
        else if (pending_in[4])
            vector_out = `VEC_VRAM_POINTER;
        else if (pending_in[3])
            vector_out = `VEC_GROUP1;
        else if (pending_in[2])
            vector_out = `VEC_SERIAL0;
        else if (pending_in[1])
            vector_out = `VEC_SERIAL1;
        else if (pending_in[0])
            vector_out = `VEC_GROUP0;
        else
            any_out = 1'b0;
    end
endmodule

/* verilog/program_sequencer_return_stack.v */
// program counter, segment select and return stack of the core
`timescale 1ns/1ns
`include "sequencer_map.vh"
module program_sequencer_return_stack (
    input  wire        mclk_in,
    input  wire        reset_in,
    input  wire        clock_stop_reset_in,
    input  wire        chip_enable_reset_in,
    input  wire        step_in,
    input  wire [3:0]  op_in,
    input  wire [12:0] operand_in,
    input  wire [6:0]  call_entry_in,
    input  wire [9:0]  irq_pending_in,
    input  wire        irq_allowed_in,
    input  wire [15:0] table_pointer_in,
    input  wire        reg_write_in,
    input  wire [3:0]  reg_addr_in,
    input  wire [3:0]  reg_wdata_in,
    input  wire [15:0] rom_data_in,
    output reg  [12:0] pc_out,
    output reg         segment_select_out,
    output reg  [13:0] fetch_addr_out,
    output reg  [3:0]  return_stack_index_out,
    output wire [3:0]  reg_rdata_out,
    output reg  [15:0] constant_buffer_out,
    output reg         constant_buffer_load_out,
    output reg  [15:0] table_pointer_out,
    output reg         table_pointer_load_out,
    output wire        irq_accept_out,
    output wire [3:0]  irq_vector_low_out
);
    localparam ST_RUN   = 2'd0;
    localparam ST_FETCH = 2'd1;
    localparam ST_POP   = 2'd2;

    reg  [13:0] return_slot [0:`STACK_SLOTS-1];
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [12:0] next_pc;
    reg         next_segment;
    reg  [3:0]  next_index;
    reg         slot_write;
    reg  [13:0] slot_wdata;
    reg  [3:0]  slot_waddr;
    wire        irq_any;
    wire [12:0] irq_vector;
    wire [13:0] read_slot;
    wire [13:0] pointer_addr;
    wire [13:0] return_addr;
    wire        index_write;
    wire        pop_pointer;

    irq_vector_select u_irq (
        .pending_in (irq_pending_in),
        .any_out    (irq_any),
        .vector_out (irq_vector)
    );

    // counter wraps inside its 13 bits; segment never carries
    function [12:0] incr_pc;
        input [12:0] value;
        begin
            incr_pc = value + 13'h0001;
        end
    endfunction

    function [13:0] pack_slot;
        input        seg;
        input [12:0] count;
        begin
            pack_slot = {seg, count};
        end
    endfunction

    // index wraps from 0 to F; a push there is then dropped
    function [3:0] dec_index;
        input [3:0] index;
        begin
            dec_index = index - 4'h1;
        end
    endfunction

    function [3:0] inc_index;
        input [3:0] index;
        begin
            inc_index = index + 4'h1;
        end
    endfunction

    // one decoder for read and write keeps the register at a single address
    function addresses_index;
        input [3:0] addr;
        begin
            addresses_index = (addr == `STACK_INDEX_ADDR);
        end
    endfunction

    assign pointer_addr  = table_pointer_in[13:0];
    assign return_addr   = pack_slot(segment_select_out, incr_pc(pc_out));
    // slot 12 is never written, so its content is whatever it holds
    assign read_slot     = return_slot[return_stack_index_out];
    assign index_write   = reg_write_in && addresses_index(reg_addr_in);
    assign reg_rdata_out = addresses_index(reg_addr_in) ? return_stack_index_out : 4'h0;
    assign pop_pointer   = step_in && (state == ST_RUN) && !irq_accept_out
                           && (op_in == `OP_POP_POINTER);
    // steps are taken only while idle; a table fetch owns the next two edges
    assign irq_accept_out     = step_in && (state == ST_RUN) && irq_allowed_in && irq_any;
    assign irq_vector_low_out = irq_vector[3:0];

    always @* begin
        next_state   = state;
        next_pc      = pc_out;
        next_segment = segment_select_out;
        next_index   = return_stack_index_out;
        slot_write   = 1'b0;
        slot_wdata   = return_addr;
        slot_waddr   = dec_index(return_stack_index_out);
        case (state)
        ST_RUN: begin
            if (step_in) begin
                next_pc = incr_pc(pc_out);
                if (irq_accept_out) begin
                    next_index = dec_index(return_stack_index_out);
                    slot_write = 1'b1;
                    slot_wdata = pack_slot(segment_select_out, pc_out);
                    next_pc    = irq_vector;
                end else begin
                    case (op_in)
                    `OP_BR_DIRECT:
                        next_pc = operand_in;
                    `OP_BR_INDIRECT: begin
                        next_pc      = pointer_addr[12:0];
                        next_segment = pointer_addr[13];
                    end
                    `OP_CALL_DIRECT: begin
                        next_index = dec_index(return_stack_index_out);
                        slot_write = 1'b1;
                        next_pc    = {2'b00, operand_in[10:0]};
                    end
                    `OP_CALL_INDIRECT: begin
                        next_index   = dec_index(return_stack_index_out);
                        slot_write   = 1'b1;
                        next_pc      = pointer_addr[12:0];
                        next_segment = pointer_addr[13];
                    end
                    `OP_SERVICE_CALL: begin
                        next_index   = dec_index(return_stack_index_out);
                        slot_write   = 1'b1;
                        next_segment = `SERVICE_SEGMENT;
                        next_pc      = {6'h00, call_entry_in};
                    end
                    `OP_RETURN, `OP_INT_RETURN: begin
                        next_pc      = read_slot[12:0];
                        next_segment = read_slot[`SLOT_SEG_BIT];
                        next_index   = inc_index(return_stack_index_out);
                    end
                    `OP_RETURN_SKIP: begin
                        next_pc      = incr_pc(read_slot[12:0]);
                        next_segment = read_slot[`SLOT_SEG_BIT];
                        next_index   = inc_index(return_stack_index_out);
                    end
                    `OP_SKIP:
                        next_pc = incr_pc(incr_pc(pc_out));
                    `OP_TABLE_FETCH: begin
                        next_index = dec_index(return_stack_index_out);
                        slot_write = 1'b1;
                        next_state = ST_FETCH;
                    end
                    `OP_PUSH_POINTER: begin
                        next_index = dec_index(return_stack_index_out);
                        slot_write = 1'b1;
                        slot_wdata = pointer_addr;
                    end
                    `OP_POP_POINTER:
                        next_index = inc_index(return_stack_index_out);
                    default: ;
                    endcase
                end
            end
        end
        ST_FETCH:
            next_state = ST_POP;
        ST_POP: begin
            next_pc      = read_slot[12:0];
            next_segment = read_slot[`SLOT_SEG_BIT];
            next_index   = inc_index(return_stack_index_out);
            next_state   = ST_RUN;
        end
        default:
            next_state = ST_RUN;
        endcase
    end

    // fetch address follows the pointer during the table read
    always @* begin
        if (state == ST_FETCH)
            fetch_addr_out = pointer_addr;
        else
            fetch_addr_out = {segment_select_out, pc_out};
    end

    // any reset abandons a running table fetch
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in)
            state <= ST_RUN;
        else if (chip_enable_reset_in || clock_stop_reset_in)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    // clock stop keeps counter and segment so execution resumes in place
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pc_out             <= 13'h0000;
            segment_select_out <= 1'b0;
        end else if (chip_enable_reset_in) begin
            pc_out             <= 13'h0000;
            segment_select_out <= 1'b0;
        end else if (!clock_stop_reset_in) begin
            pc_out             <= next_pc;
            segment_select_out <= next_segment;
        end
    end

    // a register write loses to a stack operation in the same cycle
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in)
            return_stack_index_out <= `STACK_INDEX_RESET;
        else if (chip_enable_reset_in || clock_stop_reset_in)
            return_stack_index_out <= `STACK_INDEX_RESET;
        else if (index_write && next_index == return_stack_index_out)
            return_stack_index_out <= reg_wdata_in;
        else
            return_stack_index_out <= next_index;
    end

    // buffer takes the word fetched while the pointer drives the address
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            constant_buffer_out      <= 16'h0000;
            constant_buffer_load_out <= 1'b0;
        end else if (chip_enable_reset_in || clock_stop_reset_in) begin
            constant_buffer_load_out <= 1'b0;
        end else begin
            constant_buffer_load_out <= (state == ST_FETCH);
            if (state == ST_FETCH)
                constant_buffer_out <= rom_data_in;
        end
    end

    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            table_pointer_out      <= 16'h0000;
            table_pointer_load_out <= 1'b0;
        end else if (chip_enable_reset_in || clock_stop_reset_in) begin
            table_pointer_load_out <= 1'b0;
        end else if (pop_pointer) begin
            table_pointer_out      <= {2'b00, read_slot};
            table_pointer_load_out <= 1'b1;
        end else begin
            table_pointer_load_out <= 1'b0;
        end
    end

    // slot 12 write is dropped so that it stays undefined
    always @(posedge mclk_in) begin
        if (slot_write && slot_waddr < 4'hC && !chip_enable_reset_in
                && !clock_stop_reset_in)
            return_slot[slot_waddr] <= slot_wdata;
    end
endmodule

/* tb/sequencer_properties.sv */
// assertions for the program sequencer and return stack
`timescale 1ns/1ns
`include "sequencer_map.vh"
module sequencer_properties (
    input wire        mclk_in,
    input wire        reset_in,
    input wire        clock_stop_reset_in,
    input wire        chip_enable_reset_in,
    input wire        step_in,
    input wire [3:0]  op_in,
    input wire [12:0] operand_in,
    input wire [6:0]  call_entry_in,
    input wire [9:0]  irq_pending_in,
    input wire [15:0] table_pointer_in,
    input wire [15:0] rom_data_in,
    input wire [12:0] pc_out,
    input wire        segment_select_out,
    input wire [3:0]  return_stack_index_out,
    input wire [15:0] constant_buffer_out,
    input wire        constant_buffer_load_out,
    input wire        irq_accept_out,
    input wire [3:0]  irq_vector_low_out
);
    reg  [1:0] busy;
    reg  [3:0] top;
    // steps are ignored while a table fetch is still running
    wire       go = step_in && busy == 2'd0 && !irq_accept_out && !chip_enable_reset_in
                    && !clock_stop_reset_in;
    // the design refuses steps at the two edges after the fetch step
    always @(posedge mclk_in or posedge reset_in)
        if (reset_in) busy <= 2'd0;
        else if (chip_enable_reset_in || clock_stop_reset_in) busy <= 2'd0;
        else if (busy != 2'd0) busy <= busy - 2'd1;
        else if (go && op_in == `OP_TABLE_FETCH) busy <= 2'd2;
    always @* begin
        top = 4'h0;
        for (int k = 0; k < 10; k++) if (irq_pending_in[k]) top = 4'(k + 1);
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    sequence tf_push;
        return_stack_index_out == $past(return_stack_index_out) - 4'h1;
    endsequence
    sequence tf_load;
        constant_buffer_load_out && constant_buffer_out == $past(rom_data_in);
    endsequence
    a_direct_branch: assert property (go && op_in == `OP_BR_DIRECT |=>
        pc_out == $past(operand_in) && $stable(segment_select_out)) else $error("direct branch");
    a_indirect_branch: assert property (go && op_in == `OP_BR_INDIRECT |=>
        {segment_select_out, pc_out} == $past(table_pointer_in[13:0])) else $error("indirect");
    a_direct_call: assert property (go && op_in == `OP_CALL_DIRECT |=>
        (pc_out == {2'b00, $past(operand_in[10:0])}) and tf_push) else $error("direct call");
    a_service_call: assert property (go && op_in == `OP_SERVICE_CALL |=>
        segment_select_out && pc_out == {6'h00, $past(call_entry_in)}) else $error("service");
    a_return_index: assert property (go && op_in inside {`OP_RETURN, `OP_RETURN_SKIP,
        `OP_INT_RETURN} |=> return_stack_index_out == $past(return_stack_index_out) + 4'h1)
        else $error("return index");
    a_table_fetch_order: assert property (go && op_in == `OP_TABLE_FETCH |-> ##1 tf_push
        ##1 tf_load ##1 return_stack_index_out == $past(return_stack_index_out, 3))
        else $error("table fetch");
    a_irq_priority: assert property (irq_accept_out |-> top != 4'h0
        && irq_vector_low_out == top) else $error("irq priority");
    a_enable_reset: assert property (chip_enable_reset_in |=> pc_out == 13'h0000
        && !segment_select_out && return_stack_index_out == 4'hC) else $error("enable reset");
endmodule
bind program_sequencer_return_stack sequencer_properties sequencer_properties_inst (
    .mclk_in(mclk_in), .reset_in(reset_in), .clock_stop_reset_in(clock_stop_reset_in),
    .chip_enable_reset_in(chip_enable_reset_in), .step_in(step_in), .op_in(op_in),
    .operand_in(operand_in), .call_entry_in(call_entry_in), .irq_pending_in(irq_pending_in),
    .table_pointer_in(table_pointer_in), .rom_data_in(rom_data_in), .pc_out(pc_out),
    .segment_select_out(segment_select_out), .return_stack_index_out(return_stack_index_out),
    .constant_buffer_out(constant_buffer_out), .irq_accept_out(irq_accept_out),
    .constant_buffer_load_out(constant_buffer_load_out),
    .irq_vector_low_out(irq_vector_low_out));

/* tb/rom_model.sv */
// behavioural program memory on the far side of the fetch port
`timescale 1ns/1ns
module rom_model (
    input  wire [13:0] addr_in,
    output wire [15:0] data_out
);
    // bytes differ so a swapped or truncated word shows
    assign data_out = {addr_in[7:0], ~addr_in[7:0]};
endmodule

/* tb/program_sequencer_return_stack_tb.sv */
// self-checking bench for the program sequencer and return stack
`timescale 1ns/1ns
`include "sequencer_map.vh"
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module program_sequencer_return_stack_tb;
    reg         mclk_in = 1'b0, reset_in = 1'b1, cs_rst = 0, ce_rst = 0, step = 0;
    reg         irq_ok = 0, wr = 0;
    reg  [3:0]  op = 0, addr = 0, wdata = 0;
    reg  [12:0] operand = 0;
    reg  [6:0]  entry = 0;
    reg  [9:0]  pend = 0;
    reg  [15:0] tp = 0;
    wire [15:0] rom, cbuf, tp_out;
    wire [13:0] faddr;
    wire [12:0] pc;
    wire [3:0]  idx, rdata, vec_low;
    wire        seg, cb_load, tp_load, accept;
    integer     failures = 0, samples_checked = 0, i;
    program_sequencer_return_stack program_sequencer_return_stack_inst (
        .mclk_in(mclk_in), .reset_in(reset_in), .clock_stop_reset_in(cs_rst),
        .chip_enable_reset_in(ce_rst), .step_in(step), .op_in(op), .operand_in(operand),
        .call_entry_in(entry), .irq_pending_in(pend), .irq_allowed_in(irq_ok),
        .table_pointer_in(tp), .reg_write_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .rom_data_in(rom), .pc_out(pc), .segment_select_out(seg), .fetch_addr_out(faddr),
        .return_stack_index_out(idx), .reg_rdata_out(rdata), .constant_buffer_out(cbuf),
        .constant_buffer_load_out(cb_load), .table_pointer_out(tp_out),
        .table_pointer_load_out(tp_load), .irq_accept_out(accept), .irq_vector_low_out(vec_low));
    rom_model rom_model_inst (.addr_in(faddr), .data_out(rom));
    initial forever #5 mclk_in = ~mclk_in;
    task exec(input [3:0] o, input [12:0] arg);
        begin
            // one idle edge keeps back-to-back calls from toggling step in one step
            @(negedge mclk_in);
            op = o; operand = arg; step = 1'b1;
            @(negedge mclk_in);
            step = 1'b0; op = `OP_NONE;
        end
    endtask
    task tally_and_finish;
        begin
            $display("failures=%0d samples_checked=%0d", failures, samples_checked);
            if (failures == 0 && samples_checked > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (3000) @(posedge mclk_in);
        failures++;
        $display("Error at %0t: run did not finish", $time);
        tally_and_finish;
    end
    initial begin
        repeat (4) @(negedge mclk_in);
        reset_in = 1'b0;
        `CHECK({seg, pc, idx}, {14'h0000, 4'hC})
        addr = 4'h1; wr = 1'b1; wdata = 4'h5;
        #1 `CHECK(rdata, 4'hC)
        @(negedge mclk_in);
        addr = 4'h2; wdata = 4'h9;
        @(negedge mclk_in);
        `CHECK({idx, rdata}, {4'h5, 4'h0})
        addr = 4'h1; wdata = 4'hC;
        @(negedge mclk_in);
        wr = 1'b0;
        exec(`OP_BR_DIRECT, 13'h1FFF);
        `CHECK({seg, pc}, 14'h1FFF)
        exec(`OP_NONE, 13'h0000);
        `CHECK({seg, pc}, 14'h0000)
        tp = 16'hFFFF;
        exec(`OP_BR_INDIRECT, 13'h0000);
        `CHECK({seg, pc}, 14'h3FFF)
        exec(`OP_NONE, 13'h0000);
        `CHECK({seg, pc}, 14'h2000)
        exec(`OP_CALL_DIRECT, 13'h1ABC);
        `CHECK({pc, idx}, {13'h02BC, 4'hB})
        exec(`OP_RETURN, 13'h0000);
        `CHECK({seg, pc, idx}, {14'h2001, 4'hC})
        tp = 16'h0123;
        exec(`OP_BR_INDIRECT, 13'h0000);
        for (i = 0; i < 2; i++) begin
            entry = i ? 7'h35 : 7'h7F;
            exec(`OP_SERVICE_CALL, 13'h0000);
            `CHECK({seg, pc, idx}, {7'h40, entry, 4'hB})
            exec(`OP_RETURN, 13'h0000);
            `CHECK({seg, pc, idx}, {14'h0124 + 14'(i), 4'hC})
        end
        tp = 16'hEABC;
        exec(`OP_CALL_INDIRECT, 13'h0000);
        `CHECK({seg, pc, idx}, {14'h2ABC, 4'hB})
        exec(`OP_RETURN_SKIP, 13'h0000);
        `CHECK({seg, pc, idx}, {14'h0127, 4'hC})
        tp = 16'hD234;
        exec(`OP_PUSH_POINTER, 13'h0000);
        `CHECK(idx, 4'hB)
        tp = 16'h0000;
        exec(`OP_POP_POINTER, 13'h0000);
        `CHECK({tp_load, tp_out, idx}, {1'b1, 16'h1234, 4'hC})
        exec(`OP_BR_DIRECT, 13'h0040);
        tp = 16'h2F5A;
        exec(`OP_TABLE_FETCH, 13'h0000);
        `CHECK({idx, faddr}, {4'hB, 14'h2F5A})
        @(negedge mclk_in);
        `CHECK({cb_load, cbuf}, {1'b1, 16'h5AA5})
        // a step while the return address is popped must be ignored
        step = 1'b1; op = `OP_BR_DIRECT; operand = 13'h1555;
        @(negedge mclk_in);
        `CHECK({seg, pc, idx}, {14'h0041, 4'hC})
        step = 1'b0; op = `OP_NONE;
        @(negedge mclk_in);
        // one level at a time keeps nesting far below twelve
        for (i = 0; i < 10; i++) begin
            @(negedge mclk_in);
            irq_ok = 1'b1; pend = 10'h3FF >> (9 - i); step = 1'b1;
            #1 `CHECK({accept, vec_low}, {1'b1, 4'(i + 1)})
            @(negedge mclk_in);
            step = 1'b0; pend = 10'h000; irq_ok = 1'b0;
            `CHECK({pc, idx}, {13'(i + 1), 4'hB})
            exec(`OP_INT_RETURN, 13'h0000);
            `CHECK({seg, pc, idx}, {14'h0041, 4'hC})
        end
        // pending sources without permission must not divert a skip
        pend = 10'h3FF;
        exec(`OP_SKIP, 13'h0000);
        `CHECK({seg, pc, idx}, {14'h0043, 4'hC})
        pend = 10'h000;
        exec(`OP_CALL_DIRECT, 13'h0100);
        cs_rst = 1'b1;
        @(negedge mclk_in);
        cs_rst = 1'b0;
        `CHECK({pc, idx}, {13'h0100, 4'hC})
        ce_rst = 1'b1;
        @(negedge mclk_in);
        ce_rst = 1'b0;
        `CHECK({seg, pc, idx}, {14'h0000, 4'hC})
        tally_and_finish;
    end
endmodule
